// ### shared/mdr_pkg.sv
package mdr_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int          PREAMBLE_BITS = 32;
    localparam int          ADDR_BITS     = 5;
    localparam int          DATA_BITS     = 16;
    localparam logic [1:0]  START_CODE    = 2'h1;
    localparam logic [1:0]  OP_READ       = 2'h2;
    localparam logic [1:0]  OP_WRITE      = 2'h1;
    localparam logic [1:0]  TA_WRITE      = 2'h2;
    // Bits after the preamble: start, op, phy, reg, ta, data.
    localparam int          HDR_BITS      = 14;
    localparam int          FRAME_BITS    = 32;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [4:0]  PHY_FIRST     = 5'h01;
    localparam logic [4:0]  PHY_LAST      = 5'h05;
    localparam logic [15:0] DIRECT_BASE   = 16'h0100;
    localparam logic [4:0]  REG_MMD_SETUP = 5'h0D;
    localparam logic [4:0]  REG_MMD_DATA  = 5'h0E;
    localparam logic [31:0] RESERVED_MAP  = 32'h67D1_1800;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          MDC_MAX_HZ    = 5_000_000;
    // Half period of the generated management clock, rounded up so the rate never exceeds the limit.
    localparam int          MDC_HALF_CYC  = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

    // Byte address of a direct register inside the selected port space.
    function automatic logic [15:0] mdr_byte_addr(input logic [2:0] port, input logic [4:0] regnum);
        mdr_byte_addr = {1'b0, port, 12'h000} + DIRECT_BASE + {10'h000, regnum, 1'b0};
    endfunction : mdr_byte_addr

endpackage : mdr_pkg

// ### shared/mdr_if.sv
`timescale 1ns/1ns
interface mdr_if;
    logic mdc;
    logic mdio_ctl_o;
    logic mdio_ctl_oe;
    logic mdio_dev_o;
    logic mdio_dev_oe;
    wire  mdio_line;

    // Open-drain wire with pull-up: any enabled driver pulls low only when it drives zero.
    assign mdio_line = ~((mdio_ctl_oe & ~mdio_ctl_o) | (mdio_dev_oe & ~mdio_dev_o));

    modport device (input mdc, input mdio_line, output mdio_dev_o, output mdio_dev_oe);
    modport controller (output mdc, input mdio_line, output mdio_ctl_o, output mdio_ctl_oe);
endinterface : mdr_if

// ### src/mdr_device.sv
// Behaviour
// - MDIO open-drain both sides; controller sources MDC.
// - Controller keeps MDC at or below 5 MHz.
// - Only PHY ports 1-5, no switch registers.
// - Preamble, start, op, addresses, turnaround, data, MSB-first.
// - Answer PHY addresses 1h-5h, ignore others.
// - Direct standard region plus indirect MMD region.
// - 32 direct registers, listed numbers reserved.
// - Register n maps to bytes 0xN100 plus 2n.
// - Registers shared with other register ports.
// - MMD reached through setup Dh and data Eh.
// - No use while in-band access active.
`timescale 1ns/1ns
module mdr_device
    import mdr_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    mdr_if.device            LINK,
    input  wire logic        IN_BAND_REG_ACCESS_I,
    output logic             REG_RD_O,
    output logic             REG_WR_O,
    output logic             REG_MMD_O,
    output logic [2:0]       REG_PORT_O,
    output logic [4:0]       REG_NUM_O,
    output logic [15:0]      REG_ADDR_O,
    output logic [15:0]      REG_WDATA_O,
    input  wire logic [15:0] REG_RDATA_I,
    output logic             BUSY_O
);

    typedef enum {ST_PRE, ST_HDR, ST_TA, ST_RDATA, ST_WDATA, ST_SKIP} mdr_dev_state_type;

    typedef struct packed {
        logic [1:0]        mdc_sync;
        logic [1:0]        dio_sync;
        logic              mdc_last;
        logic              iba_sync0;
        logic              iba_sync1;
        mdr_dev_state_type state;
        logic [5:0]        ones;
        logic [5:0]        cnt;
        logic [13:0]       hdr;
        logic [15:0]       shreg;
        logic              dio_o;
        logic              dio_oe;
        logic              rd;
        logic              wr;
        logic              mmd;
        logic [2:0]        port;
        logic [4:0]        regnum;
        logic [15:0]       addr;
        logic [15:0]       wdata;
        logic              busy;
    } mdr_dev_type;

    mdr_dev_type s_reg;
    mdr_dev_type s_next;

    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic bit_in;
        logic [4:0] phy;
        logic [4:0] rn;
        rise   = 1'b0;
        fall   = 1'b0;
        bit_in = 1'b0;
        phy    = 5'h00;
        rn     = 5'h00;
        s_next = s_reg;
        s_next.mdc_sync  = {s_reg.mdc_sync[0], LINK.mdc};
        s_next.dio_sync  = {s_reg.dio_sync[0], LINK.mdio_line};
        s_next.mdc_last  = s_reg.mdc_sync[1];
        s_next.iba_sync0 = IN_BAND_REG_ACCESS_I;
        s_next.iba_sync1 = s_reg.iba_sync0;
        s_next.rd        = 1'b0;
        s_next.wr        = 1'b0;
        rise   = s_reg.mdc_sync[1] & ~s_reg.mdc_last;
        fall   = ~s_reg.mdc_sync[1] & s_reg.mdc_last;
        bit_in = s_reg.dio_sync[1];
        phy    = s_reg.hdr[9:5];
        rn     = s_reg.hdr[4:0];
        if (rise) begin
            case (s_reg.state)
                ST_PRE: begin
                    // Count consecutive ones; a zero after 32 ones is the first start bit.
                    if (bit_in) begin
                        s_next.ones = (s_reg.ones == 6'(PREAMBLE_BITS)) ? s_reg.ones : s_reg.ones + 6'h01;
                    end else if (s_reg.ones == 6'(PREAMBLE_BITS)) begin
                        s_next.state = ST_HDR;
                        s_next.hdr   = 14'h0000;
                        s_next.cnt   = 6'h01;
                        s_next.busy  = 1'b1;
                    end else begin
                        s_next.ones = 6'h00;
                    end
                end
                ST_HDR: begin
                    s_next.hdr = {s_reg.hdr[12:0], bit_in};
                    s_next.cnt = s_reg.cnt + 6'h01;
                    // The first start bit was taken in ST_PRE, so thirteen header bits remain.
                    if (s_reg.cnt == 6'(HDR_BITS - 1)) begin
                        s_next.state = ST_TA;
                        s_next.cnt   = 6'h00;
                    end
                end
                ST_TA: begin
                    // Header now holds start, op, phy and reg; check it once and sort the frame.
                    s_next.cnt = s_reg.cnt + 6'h01;
                    if (s_reg.cnt == 6'h00) begin
                        s_next.port   = phy[2:0];
                        s_next.regnum = rn;
                        s_next.addr   = mdr_byte_addr(phy[2:0], rn);
                        s_next.mmd    = (rn == REG_MMD_SETUP) || (rn == REG_MMD_DATA);
                        if (s_reg.hdr[13:12] != START_CODE || s_reg.iba_sync1 ||
                            phy < PHY_FIRST || phy > PHY_LAST) begin
                            s_next.state = ST_SKIP;
                        end
                    end else begin
                        s_next.cnt = 6'h00;
                        if (s_reg.hdr[11:10] == OP_READ) begin
                            s_next.state = ST_RDATA;
                            // Reserved numbers read back as zero.
                            s_next.shreg = RESERVED_MAP[rn] ? 16'h0000 : REG_RDATA_I;
                        end else if (s_reg.hdr[11:10] == OP_WRITE) begin
                            s_next.state = ST_WDATA;
                        end else begin
                            s_next.state = ST_SKIP;
                        end
                    end
                end
                ST_WDATA: begin
                    s_next.shreg = {s_reg.shreg[14:0], bit_in};
                    s_next.cnt   = s_reg.cnt + 6'h01;
                    if (s_reg.cnt == 6'(DATA_BITS - 1)) begin
                        s_next.wdata = {s_reg.shreg[14:0], bit_in};
                        s_next.wr    = ~RESERVED_MAP[s_reg.regnum];
                        s_next.state = ST_PRE;
                        s_next.ones  = 6'h00;
                        s_next.busy  = 1'b0;
                    end
                end
                ST_RDATA: begin
                    s_next.cnt = s_reg.cnt + 6'h01;
                end
                ST_SKIP: begin
                    s_next.cnt = s_reg.cnt + 6'h01;
                    if (s_reg.cnt == 6'(DATA_BITS)) begin
                        s_next.state = ST_PRE;
                        s_next.ones  = 6'h00;
                        s_next.busy  = 1'b0;
                    end
                end
                default: begin
                    s_next.state = ST_PRE;
                end
            endcase
        end
        // Drive on the falling edge; the controller samples the bit on the rise three periods later.
        if (fall) begin
            if (s_reg.state == ST_TA && s_reg.cnt == 6'h01 && s_reg.hdr[11:10] == OP_READ) begin
                s_next.rd     = 1'b1;
                s_next.dio_oe = 1'b1;
                s_next.dio_o  = 1'b0;
            end else if (s_reg.state == ST_RDATA) begin
                if (s_reg.cnt == 6'(DATA_BITS)) begin
                    s_next.dio_oe = 1'b0;
                    s_next.dio_o  = 1'b1;
                    s_next.state  = ST_PRE;
                    s_next.ones   = 6'h00;
                    s_next.busy   = 1'b0;
                end else begin
                    s_next.dio_oe = 1'b1;
                    s_next.dio_o  = s_reg.shreg[15];
                    s_next.shreg  = {s_reg.shreg[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            // The clock detector starts at the idle low level of the clock, so no false edge follows reset.
            s_reg <= '{state: ST_PRE, dio_o: 1'b1, mdc_sync: 2'h0, dio_sync: 2'h3, mdc_last: 1'b0, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign LINK.mdio_dev_o  = s_reg.dio_o;
    assign LINK.mdio_dev_oe = s_reg.dio_oe;
    assign REG_RD_O         = s_reg.rd;
    assign REG_WR_O         = s_reg.wr;
    assign REG_MMD_O        = s_reg.mmd;
    assign REG_PORT_O       = s_reg.port;
    assign REG_NUM_O        = s_reg.regnum;
    assign REG_ADDR_O       = s_reg.addr;
    assign REG_WDATA_O      = s_reg.wdata;
    assign BUSY_O           = s_reg.busy;

endmodule : mdr_device

// ### src/mdr_controller.sv
`timescale 1ns/1ns
module mdr_controller
    import mdr_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    mdr_if.controller        LINK,
    input  wire logic        REQ_I,
    input  wire logic        REQ_WRITE_I,
    input  wire logic [4:0]  REQ_PHY_I,
    input  wire logic [4:0]  REQ_REG_I,
    input  wire logic [15:0] REQ_WDATA_I,
    output logic             READY_O,
    output logic             DONE_O,
    output logic [15:0]      RDATA_O
);

    typedef enum {CS_IDLE, CS_SEND, CS_TA, CS_DATA} mdr_ctl_state_type;

    typedef struct packed {
        mdr_ctl_state_type state;
        logic [7:0]        div;
        logic              mdc;
        logic [5:0]        cnt;
        logic [31:0]       sh;
        logic              wr;
        logic [1:0]        dio_sync;
        logic              dio_o;
        logic              dio_oe;
        logic [15:0]       rdata;
        logic              ready;
        logic              done;
    } mdr_ctl_type;

    mdr_ctl_type c_reg;
    mdr_ctl_type c_next;

    // ----------------------------------------------------------------
    // Frame sender
    // ----------------------------------------------------------------
    always_comb begin
        logic tick;
        tick   = 1'b0;
        c_next = c_reg;
        c_next.dio_sync = {c_reg.dio_sync[0], LINK.mdio_line};
        c_next.done     = 1'b0;
        if (c_reg.state != CS_IDLE) begin
            // Divided clock never exceeds the rate limit.
            tick = (c_reg.div == 8'(MDC_HALF_CYC - 1));
            c_next.div = tick ? 8'h00 : c_reg.div + 8'h01;
        end
        case (c_reg.state)
            CS_IDLE: begin
                c_next.mdc = 1'b0;
                if (REQ_I && c_reg.ready) begin
                    c_next.ready  = 1'b0;
                    c_next.state  = CS_SEND;
                    c_next.cnt    = 6'h00;
                    c_next.wr     = REQ_WRITE_I;
                    c_next.sh     = {32'hFFFF_FFFF};
                    c_next.rdata  = {REQ_WRITE_I ? OP_WRITE : OP_READ, REQ_PHY_I, REQ_REG_I, 4'h0};
                    c_next.dio_oe = 1'b1;
                    c_next.dio_o  = 1'b1;
                    c_next.div    = 8'h00;
                end
            end
            CS_SEND, CS_TA, CS_DATA: begin
                if (tick) begin
                    c_next.mdc = ~c_reg.mdc;
                    if (c_reg.mdc) begin
                        // Falling edge: present the next bit.
                        c_next.cnt = c_reg.cnt + 6'h01;
                        if (c_reg.state == CS_SEND && c_reg.cnt == 6'(PREAMBLE_BITS - 1)) begin
                            c_next.sh  = {START_CODE, c_reg.rdata[15:4], 18'h00000};
                            c_next.cnt = 6'h00;
                            c_next.state = CS_TA;
                        end else if (c_reg.state == CS_TA && c_reg.cnt == 6'(HDR_BITS - 1)) begin
                            c_next.cnt   = 6'h00;
                            c_next.state = CS_DATA;
                            c_next.sh    = c_reg.wr ? {TA_WRITE, REQ_WDATA_I, 14'h0000} : 32'h0000_0000;
                            c_next.dio_oe = c_reg.wr;
                        end else if (c_reg.state == CS_DATA &&
                                     c_reg.cnt == (c_reg.wr ? 6'(HDR_BITS + 3) : 6'(HDR_BITS + 6))) begin
                            c_next.state  = CS_IDLE;
                            c_next.dio_oe = 1'b0;
                            c_next.ready  = 1'b1;
                            c_next.done   = 1'b1;
                            c_next.mdc    = 1'b0;
                        end else begin
                            c_next.sh = {c_reg.sh[30:0], 1'b0};
                        end
                        c_next.dio_o = c_next.sh[31];
                    end else if (c_reg.state == CS_DATA && !c_reg.wr && c_reg.cnt >= 6'h05) begin
                        // Rising edge: the reply passes both ends' synchronisers, so it arrives three periods late.
                        c_next.rdata = {c_reg.rdata[14:0], c_reg.dio_sync[1]};
                    end
                end
            end
            default: begin
                c_next.state = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            c_reg <= '{state: CS_IDLE, ready: 1'b1, dio_o: 1'b1, dio_sync: 2'h3, default: '0};
        end else begin
            c_reg <= c_next;
        end
    end

    assign LINK.mdc         = c_reg.mdc;
    assign LINK.mdio_ctl_o  = c_reg.dio_o;
    assign LINK.mdio_ctl_oe = c_reg.dio_oe;
    assign READY_O          = c_reg.ready;
    assign DONE_O           = c_reg.done;
    assign RDATA_O          = c_reg.rdata;

endmodule : mdr_controller

// ### tb/mdr_checker.sv
`timescale 1ns/1ns
module mdr_checker (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic mdc,
    input wire logic mdio_ctl_o,
    input wire logic mdio_ctl_oe,
    input wire logic mdio_dev_o,
    input wire logic mdio_dev_oe,
    input wire logic mdio_line
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // Counts how long the device holds the line, so its answer length is bounded both ways.
    logic [5:0] oe_cnt_reg;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            oe_cnt_reg <= 6'h00;
        end else if (!mdio_dev_oe) begin
            oe_cnt_reg <= 6'h00;
        end else if (oe_cnt_reg != 6'h3F) begin
            oe_cnt_reg <= oe_cnt_reg + 6'h01;
        end
    end

    property p_no_contention; mdio_dev_oe |-> !mdio_ctl_oe; endproperty
    property p_mdc_rate; $rose(mdc) |=> !mdc; endproperty
    property p_preamble; $rose(mdio_ctl_oe) |-> mdio_ctl_o [*8]; endproperty
    property p_ta_zero; $rose(mdio_dev_oe) |-> !mdio_dev_o; endproperty
    property p_after_hdr; $rose(mdio_dev_oe) |-> $past(mdio_ctl_oe, 8); endproperty
    property p_dev_stands; $rose(mdio_dev_oe) |-> mdio_dev_oe [*8]; endproperty
    property p_dev_max; oe_cnt_reg <= 6'd40; endproperty
    property p_dev_len; $fell(mdio_dev_oe) |-> oe_cnt_reg inside {[6'd32:6'd40]}; endproperty

    a_no_contention: assert property (p_no_contention) else $error("both ends drive the line");
    a_mdc_rate: assert property (p_mdc_rate) else $error("clock high too long");
    a_preamble: assert property (p_preamble) else $error("preamble not ones");
    a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
    a_after_hdr: assert property (p_after_hdr) else $error("device drives outside read");
    a_dev_stands: assert property (p_dev_stands) else $error("device answer too short");
    a_dev_max: assert property (p_dev_max) else $error("device holds line too long");
    a_dev_len: assert property (p_dev_len) else $error("device answer wrong length");

    c_frame: cover property ($rose(mdio_ctl_oe));
    c_read: cover property ($rose(mdio_dev_oe));
    c_read_end: cover property ($fell(mdio_dev_oe));
endmodule : mdr_checker

// ### tb/mdio_phy_register_access_tb.sv
`timescale 1ns/1ns
module mdio_phy_register_access_tb;
    import mdr_pkg::*;
    logic        clk, rst, inband, req, req_w, rd, wr, mmd, busy, ready, done;
    logic [4:0]  req_phy, req_reg, num;
    logic [2:0]  port;
    logic [15:0] req_wd, addr, wdata, rdata_i, rdata_o, cap_addr, cap_wd, cap_pn, cap_mmd, ex;
    int          mismatches, tests_run, rd_cnt, wr_cnt, cyc, n0, m0;
    logic [4:0]  rd_regs [5] = '{5'h00, 5'h09, 5'h0D, 5'h1F, 5'h1B};
    logic [4:0]  wr_regs [5] = '{5'h0E, 5'h01, 5'h0F, 5'h11, 5'h1C};
    logic [4:0]  bad_phy [3] = '{5'h00, 5'h06, 5'h1F};

    mdr_if mdr_if_i ();
    mdr_device mdr_device_i (.CLK_I(clk), .RST_I(rst), .LINK(mdr_if_i.device), .IN_BAND_REG_ACCESS_I(inband),
        .REG_RD_O(rd), .REG_WR_O(wr), .REG_MMD_O(mmd), .REG_PORT_O(port), .REG_NUM_O(num), .REG_ADDR_O(addr),
        .REG_WDATA_O(wdata), .REG_RDATA_I(rdata_i), .BUSY_O(busy));
    mdr_controller mdr_controller_i (.CLK_I(clk), .RST_I(rst), .LINK(mdr_if_i.controller), .REQ_I(req),
        .REQ_WRITE_I(req_w), .REQ_PHY_I(req_phy), .REQ_REG_I(req_reg), .REQ_WDATA_I(req_wd), .READY_O(ready),
        .DONE_O(done), .RDATA_O(rdata_o));
    mdr_checker mdr_checker_i (.CLK_I(clk), .RST_I(rst), .mdc(mdr_if_i.mdc), .mdio_ctl_o(mdr_if_i.mdio_ctl_o),
        .mdio_ctl_oe(mdr_if_i.mdio_ctl_oe), .mdio_dev_o(mdr_if_i.mdio_dev_o),
        .mdio_dev_oe(mdr_if_i.mdio_dev_oe), .mdio_line(mdr_if_i.mdio_line));

    // ----------------------------------------------------------------
    // Clock, strobe capture and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Strobes stand one cycle; they are caught at the falling edge, where they are settled.
    always @(negedge clk) begin
        cyc++;
        if (rd === 1'b1) rd_cnt++;
        if (wr === 1'b1) begin
            wr_cnt++;
            cap_wd = wdata;
        end
        if (rd === 1'b1 || wr === 1'b1) begin
            cap_addr = addr;
            cap_pn = {8'h00, port, num};
            cap_mmd = {15'h0000, mmd};
        end
        if (cyc == 20000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic frame(input logic w, input logic [4:0] phy, input logic [4:0] rn, input logic [15:0] wd);
        int n;
        n = 0;
        @(negedge clk);
        while (ready !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        req_w = w;
        req_phy = phy;
        req_reg = rn;
        req_wd = wd;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        // Let the device finish its own late write strobe before anything is compared.
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk(16'(n < 400), 16'h0001, "frame finished");
    endtask : frame

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {inband, req, req_w, req_phy, req_reg, req_wd, rdata_i} = '0;
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk({14'h0000, ready, mdr_if_i.mdio_line}, 16'h0003, "idle after reset");
        for (int p = 1; p <= 5; p++) begin
            ex = 16'hC3A0 ^ 16'(p);
            rdata_i = ex;
            n0 = rd_cnt;
            frame(1'b0, 5'(p), rd_regs[p-1], 16'h0000);
            chk(rdata_o, ex, "read data");
            chk(16'(rd_cnt - n0), 16'h0001, "read strobe");
            chk(cap_addr, 16'h0100 + 16'(p) * 16'h1000 + 16'(rd_regs[p-1]) * 16'h0002, "address");
            chk(cap_pn, 16'(p) * 16'h0020 + 16'(rd_regs[p-1]), "port and number");
            chk(cap_mmd, 16'(rd_regs[p-1] == 5'h0D), "indirect flag");
        end
        $display("test reads done");
        for (int p = 1; p <= 5; p++) begin
            ex = 16'h8E01 + 16'(p) * 16'h0110;
            m0 = wr_cnt;
            frame(1'b1, 5'(p), wr_regs[p-1], ex);
            chk(16'(wr_cnt - m0), 16'h0001, "write strobe");
            chk(cap_wd, ex, "write data");
            chk(cap_addr, 16'h0100 + 16'(p) * 16'h1000 + 16'(wr_regs[p-1]) * 16'h0002, "address");
            chk(cap_mmd, 16'(wr_regs[p-1] == 5'h0E), "indirect flag");
        end
        $display("test writes done");
        for (int i = 0; i < 3; i++) begin
            n0 = rd_cnt;
            m0 = wr_cnt;
            frame(1'b1, bad_phy[i], 5'h01, 16'h1234);
            frame(1'b0, bad_phy[i], 5'h01, 16'h0000);
            chk(rdata_o, 16'hFFFF, "line left floating");
            chk(16'(rd_cnt - n0 + wr_cnt - m0), 16'h0000, "foreign address strobed");
        end
        $display("test foreign addresses done");
        rdata_i = 16'h1234;
        m0 = wr_cnt;
        frame(1'b0, 5'h02, 5'h0B, 16'h0000);
        chk(rdata_o, 16'h0000, "reserved read");
        frame(1'b1, 5'h04, 5'h17, 16'h5555);
        chk(16'(wr_cnt - m0), 16'h0000, "reserved write");
        $display("test reserved done");
        inband = 1'b1;
        n0 = rd_cnt;
        frame(1'b1, 5'h03, 5'h00, 16'h00FF);
        frame(1'b0, 5'h03, 5'h00, 16'h0000);
        chk(rdata_o, 16'hFFFF, "in-band read");
        chk(16'(rd_cnt - n0 + wr_cnt - m0), 16'h0000, "in-band strobe");
        inband = 1'b0;
        frame(1'b0, 5'h03, 5'h00, 16'h0000);
        chk(rdata_o, 16'h1234, "read after in-band");
        $display("test in-band done");
        end_of_test();
    end
endmodule : mdio_phy_register_access_tb
